/* File: tb/gdfes_checker.sv */
// concurrent checks on the gate driver control ports
`timescale 1ns/1ps
module gdfes_checker
    import gdfes_pkg::*;
#(
    parameter int MUTE_CYC = 40,
    parameter int FILTER_CYC = 8,
    parameter int BLANK_CYCLES = 50
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_pwm_noninv,
    input wire logic i_pwm_inv,
    input wire logic i_reset_enable,
    input wire logic i_overcurrent_sense,
    input wire logic i_supply_in_lockout,
    input wire logic i_supply_out_lockout,
    input wire logic o_gate_pull_up,
    input wire logic o_gate_pull_down,
    input wire logic o_fault_report_n_oe,
    input wire logic o_power_good_oe,
    input wire logic o_sense_pwm_out
);
    logic [15:0] lock_q, pgok_q, both_q, enlo_q, run_q, fault_q, up_q, rise_q;
    logic lock;
    assign lock = i_supply_in_lockout | i_supply_out_lockout;
    // saturating run length of a condition
    function automatic logic [15:0] sat(input logic c, input logic [15:0] n);
        return c ? n + {15'h0, n != 16'hffff} : 16'h0;
    endfunction : sat
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            lock_q <= 16'h0;
            pgok_q <= 16'h0;
            both_q <= 16'h0;
            enlo_q <= 16'h0;
        end else begin
            lock_q <= sat(lock, lock_q);
            pgok_q <= sat(!lock, pgok_q);
            both_q <= sat(i_pwm_noninv & i_pwm_inv, both_q);
            enlo_q <= sat(!i_reset_enable, enlo_q);
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            run_q <= 16'h0;
            fault_q <= 16'h0;
            up_q <= 16'h0;
            rise_q <= 16'h0;
        end else begin
            run_q <= sat(i_pwm_noninv & !i_pwm_inv & i_reset_enable & !lock
                & !i_overcurrent_sense & !o_fault_report_n_oe, run_q);
            fault_q <= sat(o_fault_report_n_oe, fault_q);
            up_q <= sat(o_gate_pull_up, up_q);
            rise_q <= sat(i_reset_enable, rise_q);
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_pair;
        o_gate_pull_down == !o_gate_pull_up;
    endproperty
    a_pair: assert property (p_pair) else $error("pull-down not inverse");
    property p_disable;
        enlo_q >= 16'h10 |-> !o_gate_pull_up;
    endproperty
    a_disable: assert property (p_disable) else $error("gate on while disabled");
    property p_lockout;
        lock_q >= 16'h10 |-> !o_gate_pull_up && o_power_good_oe && !o_sense_pwm_out;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout not held");
    property p_pg_release;
        pgok_q >= 16'h14 |-> !o_power_good_oe;
    endproperty
    a_pg_release: assert property (p_pg_release) else $error("power good held");
    property p_drive_on;
        run_q >= 16'h14 |-> o_gate_pull_up;
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("gate not driven");
    property p_interlock;
        both_q >= 16'h10 |-> !o_gate_pull_up;
    endproperty
    a_interlock: assert property (p_interlock) else $error("interlock broken");
    property p_fault_off;
        o_fault_report_n_oe && $past(o_fault_report_n_oe) |-> !o_gate_pull_up;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("gate on in fault");
    property p_fault_hold;
        $rose(o_fault_report_n_oe) |=> o_fault_report_n_oe [*8];
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
    property p_mute;
        $fell(o_fault_report_n_oe) |-> $past(fault_q) >= MUTE_CYC + FILTER_CYC;
    endproperty
    a_mute: assert property (p_mute) else $error("fault cleared early");
    property p_clear_rise;
        $fell(o_fault_report_n_oe) |-> rise_q inside {[1:24]};
    endproperty
    a_clear_rise: assert property (p_clear_rise) else $error("clear without rise");
    property p_blank;
        $rose(o_fault_report_n_oe) |-> $past(up_q) >= BLANK_CYCLES - 1;
    endproperty
    a_blank: assert property (p_blank) else $error("fault inside blanking");
    c_fault: cover property ($rose(o_fault_report_n_oe));
    c_clear: cover property ($fell(o_fault_report_n_oe));
    c_both: cover property (both_q == 16'h10);
endmodule : gdfes_checker

bind gdfes_top gdfes_checker #(.MUTE_CYC(MUTE_CYC), .FILTER_CYC(FILTER_CYC),
    .BLANK_CYCLES(BLANK_CYCLES)) u_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_pwm_noninv(i_pwm_noninv), .i_pwm_inv(i_pwm_inv), .i_reset_enable(i_reset_enable),
    .i_overcurrent_sense(i_overcurrent_sense), .i_supply_in_lockout(i_supply_in_lockout),
    .i_supply_out_lockout(i_supply_out_lockout), .o_gate_pull_up(o_gate_pull_up),
    .o_gate_pull_down(o_gate_pull_down), .o_fault_report_n_oe(o_fault_report_n_oe),
    .o_power_good_oe(o_power_good_oe), .o_sense_pwm_out(o_sense_pwm_out));

/* File: tb/gdfes_host_model.sv */
// host side model: enable driver, pull-ups on the open-drain status pins
`timescale 1ns/1ps
module gdfes_host_model (
    input wire logic i_enable_cmd,
    input wire logic i_enable_driven,
    input wire logic i_fault_o,
    input wire logic i_fault_oe,
    input wire logic i_pg_o,
    input wire logic i_pg_oe,
    output logic o_reset_enable,
    output logic o_fault_lvl,
    output logic o_pg_lvl
);
    // an undriven enable falls to the internal pull-down level
    assign o_reset_enable = i_enable_driven & i_enable_cmd;
    // open-drain pins: driven level while enabled, pull-up level once released
    assign o_fault_lvl = i_fault_oe ? i_fault_o : 1'b1;
    assign o_pg_lvl = i_pg_oe ? i_pg_o : 1'b1;
endmodule : gdfes_host_model

/* File: tb/testbench.sv */
// self-checking bench of the gate driver control block
`timescale 1ns/1ps
module testbench;
    import gdfes_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic noninv = 1'b0, inv = 1'b0, en_cmd = 1'b1, en_drv = 1'b0, ovc = 1'b0;
    logic lock_in = 1'b0, lock_out = 1'b0;
    logic [SENSE_CODE_W-1:0] mv = 13'h1388;
    logic rst_en, up, down, fault_o, fault_oe, pg_o, pg_oe, sense, fault_lvl, pg_lvl;
    int n_errors = 0, checked = 0;
    always #2 i_clock = ~i_clock;
    gdfes_top #(.MUTE_CYC(40), .FILTER_CYC(8)) dut (.i_clock(i_clock), .i_rst(i_rst),
        .i_pwm_noninv(noninv), .i_pwm_inv(inv), .i_reset_enable(rst_en),
        .i_overcurrent_sense(ovc), .i_supply_in_lockout(lock_in),
        .i_supply_out_lockout(lock_out), .i_analog_sense_in(mv), .o_gate_pull_up(up),
        .o_gate_pull_down(down), .o_fault_report_n_o(fault_o), .o_fault_report_n_oe(fault_oe),
        .o_power_good_o(pg_o), .o_power_good_oe(pg_oe), .o_sense_pwm_out(sense));
    gdfes_host_model host (.i_enable_cmd(en_cmd), .i_enable_driven(en_drv),
        .i_fault_o(fault_o), .i_fault_oe(fault_oe), .i_pg_o(pg_o), .i_pg_oe(pg_oe),
        .o_reset_enable(rst_en),
        .o_fault_lvl(fault_lvl), .o_pg_lvl(pg_lvl));
    task automatic results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge i_clock);
    endtask : idle
    // bounded wait: 0 gate pull-up, 1 fault drive, 2 sense output
    task automatic wait_on(input int sel, input logic v, input int lim);
        logic got;
        for (int i = 0; i < lim; i++) begin
            @(negedge i_clock);
            got = (sel == 0) ? up : (sel == 1) ? fault_oe : sense;
            if (got === v) return;
        end
        chk({15'h0, ~v}, {15'h0, v});
        results();
    endtask : wait_on
    task automatic t_enable;
        noninv = 1'b1;
        idle(40);
        chk(up, 1'b0);
        chk(pg_lvl, 1'b1);
        en_drv = 1'b1;
        wait_on(0, 1'b1, 60);
        chk(down, 1'b0);
        chk(fault_lvl, 1'b1);
    endtask : t_enable
    task automatic t_interlock_disable;
        inv = 1'b1;
        idle(30);
        chk(up, 1'b0);
        inv = 1'b0;
        en_cmd = 1'b0;
        idle(30);
        chk(down, 1'b1);
        en_cmd = 1'b1;
        wait_on(0, 1'b1, 60);
    endtask : t_interlock_disable
    task automatic t_lockout(input logic side);
        lock_in = !side;
        lock_out = side;
        idle(30);
        chk(up, 1'b0);
        chk(pg_lvl, 1'b0);
        chk(sense, 1'b0);
        lock_in = 1'b0;
        lock_out = 1'b0;
        idle(30);
        chk(pg_lvl, 1'b1);
        chk(up, 1'b1);
    endtask : t_lockout
    task automatic t_sense(input logic [12:0] code, input logic [15:0] hi);
        logic [15:0] nh, np;
        mv = code;
        idle(1300);
        wait_on(2, 1'b0, 700);
        wait_on(2, 1'b1, 700);
        nh = 16'h1;
        @(negedge i_clock);
        while (sense === 1'b1 && nh < 16'h2bc) begin
            nh++;
            @(negedge i_clock);
        end
        np = nh;
        while (sense === 1'b0 && np < 16'h578) begin
            np++;
            @(negedge i_clock);
        end
        chk(nh, hi);
        chk(np, 16'h271);
    endtask : t_sense
    task automatic t_fault;
        // overcurrent raised only once the gate is already off
        inv = 1'b1;
        idle(20);
        ovc = 1'b1;
        idle(40);
        chk(fault_lvl, 1'b1);
        inv = 1'b0;
        wait_on(1, 1'b1, 200);
        idle(1);
        chk(up, 1'b0);
        ovc = 1'b0;
        en_cmd = 1'b0;
        idle(12);
        en_cmd = 1'b1;
        idle(40);
        chk(fault_lvl, 1'b0);
        chk(up, 1'b0);
        en_cmd = 1'b0;
        idle(30);
        chk(fault_lvl, 1'b0);
        en_cmd = 1'b1;
        wait_on(1, 1'b0, 40);
        chk(fault_lvl, 1'b1);
        wait_on(0, 1'b1, 60);
    endtask : t_fault
    initial begin
        idle(12);
        i_rst = 1'b0;
        t_enable();
        t_interlock_disable();
        t_lockout(1'b0);
        t_lockout(1'b1);
        t_sense(13'h1388, 16'h3e);
        t_sense(13'h1194, 16'h3e);
        t_sense(13'h0258, 16'h226);
        t_sense(13'h0000, 16'h226);
        t_fault();
        results();
    end
endmodule : testbench

/* File: verilog/gdfes_pkg.sv */
// constants and types of the gate driver fault, enable and sense control
package gdfes_pkg;
    localparam int CLOCK_MHZ = 250;
    // input deglitch filter
    localparam int DEGLITCH_NS = 40;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLOCK_MHZ + 999) / 1000;
    // leading edge blanking after pull-up turns on
    localparam int BLANK_NS = 200;
    localparam int BLANK_CYC = (BLANK_NS * CLOCK_MHZ + 999) / 1000;
    // fault mute interval and clear filter time (no figure given: plain defaults)
    localparam int FAULT_MUTE_NS = 20000;
    localparam int FAULT_MUTE_CYC = (FAULT_MUTE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CLEAR_FILTER_NS = 1000;
    localparam int CLEAR_FILTER_CYC = (CLEAR_FILTER_NS * CLOCK_MHZ + 999) / 1000;
    // sense encoder: 400 kHz carrier
    localparam int SENSE_PWM_KHZ = 400;
    localparam int SENSE_PERIOD_CYC = CLOCK_MHZ * 1000 / SENSE_PWM_KHZ;
    // duty in tenths of a percent
    localparam int DUTY_MIN_PM = 100;
    localparam int DUTY_MAX_PM = 880;
    // sense voltage code in millivolts
    localparam int SENSE_CODE_W = 13;
    localparam int SENSE_HIGH_MV = 4500;
    localparam int SENSE_LOW_MV = 600;
    localparam int TIMER_W = 16;
    typedef enum logic [1:0] {
        GDFES_RUN,
        GDFES_MUTE,
        GDFES_WAIT_CLEAR,
        GDFES_WAIT_RISE
    } gdfes_fault_t;
endpackage : gdfes_pkg

/* File: verilog/gdfes_sense_pwm.sv */
// analog sense code to pwm duty encoder
`timescale 1ns/1ps
module gdfes_sense_pwm
    import gdfes_pkg::*;
#(
    parameter int PERIOD_CYC = SENSE_PERIOD_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [SENSE_CODE_W-1:0] i_sense_mv,
    output logic o_pwm
);
    localparam int CNT_W = $clog2(PERIOD_CYC + 1);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] high_q;

    // duty cycles from voltage: linear, clamped at both ends
    function automatic logic [CNT_W-1:0] duty_cycles(input logic [SENSE_CODE_W-1:0] mv);
        int v;
        int pm;
        v = int'(mv);
        if (v > SENSE_HIGH_MV)
            v = SENSE_HIGH_MV;
        if (v < SENSE_LOW_MV)
            v = SENSE_LOW_MV;
        pm = DUTY_MIN_PM + (SENSE_HIGH_MV - v) * (DUTY_MAX_PM - DUTY_MIN_PM)
             / (SENSE_HIGH_MV - SENSE_LOW_MV);
        return CNT_W'(pm * PERIOD_CYC / 1000);
    endfunction : duty_cycles

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            count_q <= '0;
        end else if (!i_enable) begin
            count_q <= '0;
        end else if (count_q == CNT_W'(PERIOD_CYC - 1)) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

    // duty latched at period start so a period is never torn
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            high_q <= '0;
        end else if (count_q == '0) begin
            high_q <= duty_cycles(i_sense_mv);
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pwm <= 1'b0;
        end else begin
            o_pwm <= i_enable && (count_q < high_q);
        end
    end
endmodule : gdfes_sense_pwm

/* File: verilog/gdfes_top.sv */
// gate driver fault latch, enable filter, interlock, lockout and sense encoder
`timescale 1ns/1ps
module gdfes_top
    import gdfes_pkg::*;
#(
    parameter int MUTE_CYC = FAULT_MUTE_CYC,
    parameter int FILTER_CYC = CLEAR_FILTER_CYC,
    parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
    parameter int BLANK_CYCLES = BLANK_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_pwm_noninv,
    input wire logic i_pwm_inv,
    input wire logic i_reset_enable,
    input wire logic i_overcurrent_sense,
    input wire logic i_supply_in_lockout,
    input wire logic i_supply_out_lockout,
    input wire logic [SENSE_CODE_W-1:0] i_analog_sense_in,
    output logic o_gate_pull_up,
    output logic o_gate_pull_down,
    output logic o_fault_report_n_o,
    output logic o_fault_report_n_oe,
    output logic o_power_good_o,
    output logic o_power_good_oe,
    output logic o_sense_pwm_out
);
    // ------------------------------------------------------------
    // input synchronisers and deglitch
    // ------------------------------------------------------------
    localparam int NIN = 5;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    logic [NIN-1:0] clean_q;
    logic [TIMER_W-1:0] dg_q [NIN];

    assign raw = {i_supply_out_lockout, i_supply_in_lockout, i_overcurrent_sense,
                  i_reset_enable, i_pwm_inv ^ 1'b0};

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // noninverting input handled through its own synchroniser below
    logic [2:0] nin_q;
    logic nin_clean_q;
    logic [TIMER_W-1:0] nin_dg_q;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            nin_q <= '0;
        end else begin
            nin_q <= {nin_q[1:0], i_pwm_noninv};
        end
    end

    // pulses shorter than the deglitch time are dropped
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            nin_clean_q <= 1'b0;
            nin_dg_q <= '0;
        end else if (nin_q[1] != nin_q[2] || nin_q[2] == nin_clean_q) begin
            nin_dg_q <= '0;
        end else if (nin_dg_q == TIMER_W'(DEGLITCH_CYCLES - 1)) begin
            nin_dg_q <= '0;
            nin_clean_q <= nin_q[2];
        end else begin
            nin_dg_q <= nin_dg_q + 1'b1;
        end
    end

    // lockout bits reset to asserted: outputs stay safe until supplies are seen
    localparam logic [NIN-1:0] CLEAN_RST = 5'h18;
    for (genvar g = 0; g < NIN; g++) begin : g_dg
        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                clean_q[g] <= CLEAN_RST[g];
                dg_q[g] <= '0;
            end else if (s2_q[g] != s3_q[g] || s3_q[g] == clean_q[g]) begin
                dg_q[g] <= '0;
            end else if (dg_q[g] == TIMER_W'(DEGLITCH_CYCLES - 1)) begin
                dg_q[g] <= '0;
                clean_q[g] <= s3_q[g];
            end else begin
                dg_q[g] <= dg_q[g] + 1'b1;
            end
        end
    end

    logic inv;
    logic rst_en;
    logic overcurrent_sense;
    logic lockout;
    assign inv = clean_q[0];
    assign rst_en = clean_q[1];
    assign overcurrent_sense = clean_q[2];
    assign lockout = clean_q[3] | clean_q[4];

    // ------------------------------------------------------------
    // enable filter: low longer than the filter time disables
    // ------------------------------------------------------------
    logic [TIMER_W-1:0] low_q;
    logic enabled_q;
    logic rst_en_d1_q;
    logic low_long;
    gdfes_fault_t fstate_q;

    assign low_long = (low_q == TIMER_W'(FILTER_CYC));

    // low time counts only outside the mute interval
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            low_q <= '0;
        end else if (rst_en || fstate_q == GDFES_MUTE) begin
            low_q <= '0;
        end else if (!low_long) begin
            low_q <= low_q + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            enabled_q <= 1'b0;
            rst_en_d1_q <= 1'b0;
        end else begin
            rst_en_d1_q <= rst_en;
            if (low_long) begin
                enabled_q <= 1'b0;
            end else if (rst_en) begin
                enabled_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // fault latch with mute and clear sequence
    // ------------------------------------------------------------
    logic [TIMER_W-1:0] mute_q;
    logic [TIMER_W-1:0] blank_q;
    logic fault_hit;

    // detection only while on and past the blanking time
    assign fault_hit = overcurrent_sense && o_gate_pull_up && (blank_q == TIMER_W'(BLANK_CYCLES));

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            blank_q <= '0;
        end else if (!o_gate_pull_up) begin
            blank_q <= '0;
        end else if (blank_q != TIMER_W'(BLANK_CYCLES)) begin
            blank_q <= blank_q + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            fstate_q <= GDFES_RUN;
            mute_q <= '0;
        end else begin
            unique case (fstate_q)
                GDFES_RUN: begin
                    if (fault_hit) begin
                        fstate_q <= GDFES_MUTE;
                        mute_q <= '0;
                    end
                end
                GDFES_MUTE: begin
                    if (mute_q == TIMER_W'(MUTE_CYC - 1)) begin
                        fstate_q <= GDFES_WAIT_CLEAR;
                    end else begin
                        mute_q <= mute_q + 1'b1;
                    end
                end
                GDFES_WAIT_CLEAR: begin
                    if (low_long) begin
                        fstate_q <= GDFES_WAIT_RISE;
                    end
                end
                GDFES_WAIT_RISE: begin
                    if (rst_en && !rst_en_d1_q) begin
                        fstate_q <= GDFES_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // gate outputs and status pins
    // ------------------------------------------------------------
    logic gate_on;
    assign gate_on = !lockout && enabled_q && rst_en && nin_clean_q && !inv
                     && fstate_q == GDFES_RUN && !fault_hit;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_gate_pull_up <= 1'b0;
            o_gate_pull_down <= 1'b1;
        end else begin
            o_gate_pull_up <= gate_on;
            o_gate_pull_down <= !gate_on;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_fault_report_n_o <= 1'b0;
            o_fault_report_n_oe <= 1'b0;
            o_power_good_o <= 1'b0;
            o_power_good_oe <= 1'b1;
        end else begin
            o_fault_report_n_o <= 1'b0;
            o_fault_report_n_oe <= fault_hit || fstate_q != GDFES_RUN;
            o_power_good_o <= 1'b0;
            o_power_good_oe <= lockout;
        end
    end

    gdfes_sense_pwm #(
        .PERIOD_CYC(SENSE_PERIOD_CYC)
    ) u_sense (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(!lockout),
        .i_sense_mv(i_analog_sense_in),
        .o_pwm(o_sense_pwm_out)
    );
endmodule : gdfes_top
